// >>> hw/drbc_top.v
/*
  DMA request and burst control: four channels of request flags, channel
  acceptance, burst and cycle-steal arbitration, bus ownership against
  refresh and hold, and byte-lane strobes, with an AXI4-Lite register bus.
  Assumes every input is synchronous to mclk_i; the bus cycle engine that
  moves data is outside and reports each cycle's end on cycle_end_i.
*/
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "drbc_consts.vh"

module drbc_top #(
  parameter NCH = 4  // Number of channels.
) (
  input  wire              mclk_i,                   // System clock, 100 MHz.
  input  wire              reset_n_i,                // Asynchronous active-low reset.
  input  wire [7:0]        s_axi_awaddr,             // Write address.
  input  wire              s_axi_awvalid,            // Write address valid.
  output reg               s_axi_awready,            // Write address ready.
  input  wire [31:0]       s_axi_wdata,              // Write data.
  input  wire [3:0]        s_axi_wstrb,              // Write byte strobes.
  input  wire              s_axi_wvalid,             // Write data valid.
  output reg               s_axi_wready,             // Write data ready.
  output reg  [1:0]        s_axi_bresp,              // Write response.
  output reg               s_axi_bvalid,             // Write response valid.
  input  wire              s_axi_bready,             // Write response ready.
  input  wire [7:0]        s_axi_araddr,             // Read address.
  input  wire              s_axi_arvalid,            // Read address valid.
  output reg               s_axi_arready,            // Read address ready.
  output reg  [31:0]       s_axi_rdata,              // Read data.
  output reg  [1:0]        s_axi_rresp,              // Read response.
  output reg               s_axi_rvalid,             // Read data valid.
  input  wire              s_axi_rready,             // Read data ready.
  input  wire [NCH-1:0]    channel_request_pin_n_i,  // Request pins, active low.
  input  wire              terminate_transfer_pin_n_i, // Terminate pin, active low.
  input  wire [12:0]       periph_req_i,             // Shared peripheral pulses.
  input  wire              refresh_req_i,            // DRAM refresh wants the bus.
  input  wire              hold_req_i,               // External hold wants the bus.
  input  wire              bus_width8_i,             // External bus is 8 bits wide.
  input  wire              addr_odd_i,               // Current address is odd.
  input  wire              cycle_end_i,              // Current bus cycle ends.
  output reg               refresh_grant_o,          // Bus granted to refresh.
  output reg               hold_grant_o,             // Bus granted to hold.
  output reg               dma_grant_o,              // Bus granted to DMA.
  output reg               cpu_grant_o,              // Bus granted to CPU.
  output reg  [1:0]        active_ch_o,              // Channel being served.
  output reg               one_cycle_o,              // Single-cycle method active.
  output reg               low_byte_strobe_n_o,      // Low byte-lane strobe.
  output reg               high_byte_strobe_n_o      // High byte-lane strobe.
);

  localparam ST_IDLE  = 2'b00;  // CPU owns the bus, nothing accepted.
  localparam ST_XFER  = 2'b01;  // DMA runs transfer cycles.
  localparam ST_PAUSE = 2'b10;  // Bus lent to refresh or hold.
  localparam ST_BACK  = 2'b11;  // One bus cycle back to the CPU.

  // Register state per channel, then the arbiter state.
  reg  [7:0]  mode_q   [0:NCH-1];   // Channel mode registers.
  reg  [3:0]  src_q    [0:NCH-1];   // Trigger selection.
  reg         sense_q  [0:NCH-1];   // Level sensing when set.
  reg  [15:0] count_q  [0:NCH-1];   // Remaining transfer units.
  reg  [NCH-1:0] enable_q;          // Channel enable bits.
  reg  [NCH-1:0] swreq_q;           // Software request bits.
  reg  [1:0]  state_q;              // Arbiter state.
  reg  [1:0]  owner_q;              // Channel holding the bus.

  wire [NCH-1:0] flag;              // Request flags from the channels.
  wire [NCH-1:0] ready;             // Flag and enable both set.
  wire           wr_go;             // Write address and data both offered.
  wire [3:0]     wr_idx;            // Low nibble of write offset.
  wire [3:0]     wr_grp;            // Register group of write offset.
  wire           other_bus;         // Refresh or hold wants the bus.
  wire           burst;             // Owner runs in burst mode.
  wire           owner_lvl;         // Owner is level sensed.
  wire           last_unit;         // Current cycle moves the last unit.
  wire           term;              // Terminate pin sampled low.
  wire [1:0]     pick;              // Highest ready channel.

  // Fixed priority pick, channel zero highest.
  function [1:0] prio;
    input [3:0] r;
    begin
      if (r[0])      prio = 2'd0;
      else if (r[1]) prio = 2'd1;
      else if (r[2]) prio = 2'd2;
      else           prio = 2'd3;
    end
  endfunction

  // Offset decode shared by the read and write paths.
  function valid_ofs;
    input [7:0] a;
    begin
      valid_ofs = (a == `DRBC_OFS_GLOBAL) || (a == `DRBC_OFS_STATUS) ||
                  ((a[7:4] >= 4'h1) && (a[7:4] <= 4'h3) && (a[3:0] < 4'hD) &&
                   (a[1:0] == 2'b00));
    end
  endfunction

  assign ready     = flag & enable_q;
  assign pick      = prio(ready);
  assign other_bus = refresh_req_i | hold_req_i;
  assign burst     = ~mode_q[owner_q][`DRBC_MODE_STEAL];
  assign owner_lvl = sense_q[owner_q] & burst &
                     (src_q[owner_q] == `DRBC_SRC_PIN);
  assign last_unit = (count_q[owner_q] == 16'h0001);
  assign term      = ~terminate_transfer_pin_n_i & (state_q == ST_XFER);
  assign wr_go     = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign wr_idx    = s_axi_awaddr[3:0];
  assign wr_grp    = s_axi_awaddr[7:4];

  // One flag engine per channel.
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      drbc_chan u_chan (
        .mclk_i       (mclk_i),
        .reset_n_i    (reset_n_i),
        .src_sel_i    (src_q[g]),
        .level_i      (sense_q[g]),
        .steal_i      (mode_q[g][`DRBC_MODE_STEAL]),
        .enable_i     (enable_q[g]),
        .req_pin_n_i  (channel_request_pin_n_i[g]),
        .sw_req_i     (swreq_q[g]),
        .periph_req_i (periph_req_i),
        .flag_wr_i    (wr_go && wr_grp == 4'h2 && wr_idx == g * 4),
        .flag_wdata_i (s_axi_wdata[`DRBC_CTL_FLAG]),
        .done_i       (state_q == ST_XFER && owner_q == g &&
                       cycle_end_i && last_unit),
        .term_i       (term && owner_q == g),
        .steal_take_i (state_q == ST_XFER && owner_q == g &&
                       mode_q[g][`DRBC_MODE_STEAL] && cycle_end_i),
        .flag_o       (flag[g])
      );
    end
  endgenerate

  // Register writes, enable handling and the transfer counter. Both AXI
  // write channels are taken together in one cycle, so order never matters.
  integer i;
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (i = 0; i < NCH; i = i + 1) begin
        mode_q[i]  <= `DRBC_RST_MODE;
        src_q[i]   <= 4'h0;
        sense_q[i] <= 1'b0;
        count_q[i] <= 16'h0000;
      end
      enable_q      <= {NCH{1'b0}};
      swreq_q       <= {NCH{1'b0}};
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Software request bits self-clear once the flag stands.
      for (i = 0; i < NCH; i = i + 1) begin
        if (flag[i]) begin
          swreq_q[i] <= 1'b0;
        end
      end
      // Transfer bookkeeping: count down and drop enable on completion
      // or forced termination; a level-sensed pause leaves it alone.
      if (state_q == ST_XFER && cycle_end_i) begin
        count_q[owner_q] <= count_q[owner_q] - 16'h0001;
        if (last_unit) begin
          enable_q[owner_q] <= 1'b0;
        end
      end
      if (term) begin
        enable_q[owner_q] <= 1'b0;
      end
      if (wr_go && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= valid_ofs(s_axi_awaddr) ? 2'b00 : 2'b10;
        if (s_axi_awaddr == `DRBC_OFS_GLOBAL && s_axi_wstrb[1]) begin
          swreq_q <= swreq_q | s_axi_wdata[`DRBC_GLB_SWREQ_LSB +: NCH];
        end
        for (i = 0; i < NCH; i = i + 1) begin
          if (wr_idx == i * 4 && s_axi_wstrb[0]) begin
            if (wr_grp == 4'h1) begin
              mode_q[i] <= s_axi_wdata[7:0];
            end
            if (wr_grp == 4'h2) begin
              src_q[i]    <= s_axi_wdata[3:0];
              sense_q[i]  <= s_axi_wdata[`DRBC_CTL_SENSE];
              enable_q[i] <= s_axi_wdata[`DRBC_CTL_ENABLE];
            end
          end
          if (wr_idx == i * 4 && wr_grp == 4'h3 && s_axi_wstrb[1:0] == 2'b11) begin
            count_q[i] <= s_axi_wdata[15:0];
          end
        end
      end
    end
  end

  // Register reads.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= valid_ofs(s_axi_araddr) ? 2'b00 : 2'b10;
        s_axi_rdata   <= 32'h00000000;
        case (s_axi_araddr[7:4])
          4'h0: begin
            if (s_axi_araddr[3:0] == 4'h0)
              s_axi_rdata <= {20'h00000, swreq_q, 8'h00};
            else if (s_axi_araddr[3:0] == 4'h4)
              s_axi_rdata <= {24'h000000, 1'b0, state_q, owner_q, 3'b000} |
                             {28'h0000000, flag};
          end
          4'h1: s_axi_rdata <= {24'h000000, mode_q[s_axi_araddr[3:2]]};
          4'h2: s_axi_rdata <= {25'h0000000, enable_q[s_axi_araddr[3:2]],
                                flag[s_axi_araddr[3:2]], sense_q[s_axi_araddr[3:2]],
                                src_q[s_axi_araddr[3:2]]};
          4'h3: s_axi_rdata <= {16'h0000, count_q[s_axi_araddr[3:2]]};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Bus ownership arbiter. Refresh and hold outrank DMA, DMA outranks CPU.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
      owner_q <= 2'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (!other_bus && ready != {NCH{1'b0}}) begin
            state_q <= ST_XFER;
            owner_q <= pick;
          end
        end
        ST_XFER: begin
          if (term || !enable_q[owner_q]) begin
            state_q <= ST_BACK;
          end else if (cycle_end_i) begin
            if (last_unit) begin
              state_q <= ST_BACK;
            end else if (other_bus) begin
              state_q <= ST_PAUSE;
            end else if (!burst) begin
              // Cycle steal: re-arbitrate at each cycle end.
              if (ready != {NCH{1'b0}}) owner_q <= pick;
              else state_q <= ST_BACK;
            end else if (owner_lvl && channel_request_pin_n_i[owner_q]) begin
              state_q <= ST_BACK;
            end
            // Otherwise burst holds the owner.
          end
        end
        ST_PAUSE: begin
          if (!other_bus) begin
            state_q <= ST_XFER;
          end
        end
        ST_BACK: begin
          if (cycle_end_i) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Grant and strobe outputs, all registered.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      refresh_grant_o      <= 1'b0;
      hold_grant_o         <= 1'b0;
      dma_grant_o          <= 1'b0;
      cpu_grant_o          <= 1'b1;
      active_ch_o          <= 2'd0;
      one_cycle_o          <= 1'b0;
      low_byte_strobe_n_o  <= 1'b1;
      high_byte_strobe_n_o <= 1'b1;
    end else begin
      refresh_grant_o <= refresh_req_i;
      hold_grant_o    <= hold_req_i & ~refresh_req_i;
      dma_grant_o     <= ~other_bus & (state_q == ST_XFER);
      cpu_grant_o     <= ~other_bus & (state_q != ST_XFER);
      active_ch_o     <= owner_q;
      one_cycle_o     <= (state_q == ST_XFER) & mode_q[owner_q][`DRBC_MODE_ONECYC];
      low_byte_strobe_n_o  <= 1'b1;
      high_byte_strobe_n_o <= 1'b1;
      // Strobes only while the DMA side holds the bus grant.
      if (state_q == ST_XFER && !other_bus && mode_q[owner_q][`DRBC_MODE_ONECYC]) begin
        if (bus_width8_i) begin
          low_byte_strobe_n_o <= 1'b0;
        end else if (!mode_q[owner_q][`DRBC_MODE_UNIT8]) begin
          low_byte_strobe_n_o  <= 1'b0;
          high_byte_strobe_n_o <= 1'b0;
        end else begin
          low_byte_strobe_n_o  <= addr_odd_i;
          high_byte_strobe_n_o <= ~addr_odd_i;
        end
      end
    end
  end

endmodule // drbc_top
`default_nettype wire

// >>> hw/drbc_consts.vh
/*
  Constants for the DMA request and burst control block: register byte
  offsets, field positions, reset values and timing counts.
  Assumes it is included by bare name from design files under hw/.
*/
// How it works
// - Byte strobes follow unit size and bus width.
// - Four-bit trigger select per channel; zero prohibited.
// - Peripheral requests arrive with their interrupt timing.
// - Software request bit sets the channel request flag.
// - Software request bit self-clears once flag set.
// - Request pin sets flag when external trigger chosen.
// - Accept only when enable and flag both set.
// - Reset clears enables; software programs then enables.
// - Mode bit: burst at zero, cycle steal at one.
// - Burst owner blocks other channels until finished.
// - Sense bit: edge or level, pin source, burst.
// - Falling pin edge sets flag in edge mode.
// - Edge flag cleared by disable, software, done, terminate.
// - Bus priority: refresh, hold, DMA, then CPU.
// - Higher request pauses after cycle, resumes later.
// - After burst, bus returns to CPU first.
// - Level mode flag simply follows pin low.
// - Pin high mid-burst stops, enable stays set.
// - Pin low again resumes at next address.
// - Whole completion clears enable, frees bus.
// - Method bit: two-cycle at zero, single-cycle one.
// - Unit bit: sixteen bits at zero, eight one.
// - Fixed priority: channel zero highest, three lowest.
`ifndef DRBC_CONSTS_VH
`define DRBC_CONSTS_VH

// Register byte offsets on the 32-bit register bus.
`define DRBC_OFS_GLOBAL   8'h00
`define DRBC_OFS_STATUS   8'h04
`define DRBC_OFS_MODE0    8'h10
`define DRBC_OFS_CTRL0    8'h20
`define DRBC_OFS_COUNT0   8'h30

// Global control fields: software request bits 8 through 11.
`define DRBC_GLB_SWREQ_LSB 8

// Channel mode fields.
`define DRBC_MODE_UNIT8    0
`define DRBC_MODE_ONECYC   1
`define DRBC_MODE_STEAL    2

// Channel control fields.
`define DRBC_CTL_SRC_LSB   0
`define DRBC_CTL_SENSE     4
`define DRBC_CTL_FLAG      5
`define DRBC_CTL_ENABLE    6

// Trigger source codes.
`define DRBC_SRC_PIN       4'h1
`define DRBC_SRC_SOFT      4'h2

// Reset values.
`define DRBC_RST_MODE      8'h00
`define DRBC_RST_CTRL      8'h00

// Bus cycle length of one DMA transfer cycle, in clocks.
`define DRBC_CYCLE_CLKS    2

`endif

// >>> hw/drbc_chan.v
/*
  One DMA channel's request flag logic: trigger selection, edge or level
  sensing, software request and the flag clearing conditions.
  Assumes all inputs are synchronous to mclk_i and that the parent
  decides acceptance and completion.
*/
`timescale 1ns/1ps
`default_nettype none
`include "drbc_consts.vh"

module drbc_chan (
  input  wire        mclk_i,        // System clock.
  input  wire        reset_n_i,     // Asynchronous active-low reset.
  input  wire [3:0]  src_sel_i,     // Trigger selection code.
  input  wire        level_i,       // One selects level sensing.
  input  wire        steal_i,       // One selects cycle-steal mode.
  input  wire        enable_i,      // Channel enable bit.
  input  wire        req_pin_n_i,   // Channel request pin, active low.
  input  wire        sw_req_i,      // Software request bit for this channel.
  input  wire [12:0] periph_req_i,  // Peripheral pulses for codes 3 to 15.
  input  wire        flag_wr_i,     // Software writes the flag this cycle.
  input  wire        flag_wdata_i,  // Value written to the flag.
  input  wire        done_i,        // Whole transfer completed.
  input  wire        term_i,        // Terminate pin low during own transfer.
  input  wire        steal_take_i,  // Cycle-steal transfer cycle ended.
  output wire        flag_o         // Request flag.
);

  reg  pin_prev_q;  // Last sampled pin level for falling-edge detection.
  reg  en_prev_q;   // Last enable value; only its falling edge clears.
  reg  flag_q;      // Request flag.
  reg  flag_d;      // Next request flag.
  wire fall;        // Falling edge on request pin.
  wire set_ev;      // Event that sets the flag.
  wire lvl_mode;    // Level sensing actually in force.

  assign fall     = pin_prev_q & ~req_pin_n_i;
  assign lvl_mode = level_i & ~steal_i &
                    (src_sel_i == `DRBC_SRC_PIN);

  // Peripheral pulses already carry their interrupt timing, so they pass
  // straight through; code zero selects nothing.
  assign set_ev = ((src_sel_i == `DRBC_SRC_PIN) & fall) |
                  ((src_sel_i == `DRBC_SRC_SOFT) & sw_req_i) |
                  ((src_sel_i > `DRBC_SRC_SOFT) &
                   periph_req_i[src_sel_i - 4'h3]);

  // Next flag: clears apply first, so a set in the same cycle wins.
  always @* begin
    flag_d = flag_q;
    if (lvl_mode) begin
      flag_d = ~req_pin_n_i;
    end else begin
      // A flag may be set while the channel is disabled; only the act of
      // clearing the enable bit throws it away.
      if ((en_prev_q && !enable_i) || done_i || term_i || steal_take_i) begin
        flag_d = 1'b0;
      end
      if (flag_wr_i && !flag_wdata_i) begin
        flag_d = 1'b0;
      end
      if (flag_wr_i && flag_wdata_i) begin
        flag_d = 1'b1;
      end
      if (set_ev) begin
        flag_d = 1'b1;
      end
    end
  end

  // Flag and pin history registers.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_q     <= 1'b0;
      pin_prev_q <= 1'b1;
      en_prev_q  <= 1'b0;
    end else begin
      flag_q     <= flag_d;
      pin_prev_q <= req_pin_n_i;
      en_prev_q  <= enable_i;
    end
  end

  assign flag_o = flag_q;

endmodule // drbc_chan
`default_nettype wire

// >>> verif/drbc_asserts.sv
/*
  Checker on the drbc_top ports: bus ownership, owner stability and strobes.
  Assumes it is bound to every drbc_top instance by the bind below.
*/
`timescale 1ns/1ps
`default_nettype none
module drbc_asserts (
  input wire logic       mclk_i,
  input wire logic       reset_n_i,
  input wire logic       refresh_req_i,
  input wire logic       hold_req_i,
  input wire logic       bus_width8_i,
  input wire logic       refresh_grant_o,
  input wire logic       hold_grant_o,
  input wire logic       dma_grant_o,
  input wire logic       cpu_grant_o,
  input wire logic [1:0] active_ch_o,
  input wire logic       one_cycle_o,
  input wire logic       low_byte_strobe_n_o,
  input wire logic       high_byte_strobe_n_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // The bus has exactly one owner in every cycle.
  a_grant_onehot: assert property ($onehot({refresh_grant_o, hold_grant_o, dma_grant_o, cpu_grant_o}))
    else $error("bus grant not one-hot");
  // Refresh and hold only own the bus while they ask for it.
  a_refresh_cause: assert property (refresh_grant_o |-> $past(refresh_req_i))
    else $error("refresh granted without request");
  a_hold_cause: assert property (hold_grant_o |-> $past(hold_req_i))
    else $error("hold granted without request");
  // A burst owner never changes while it keeps the bus.
  a_owner_stable: assert property (dma_grant_o && $past(dma_grant_o) |-> $stable(active_ch_o))
    else $error("owner channel changed mid-burst");
  // The bus goes back to others for at least two cycles after a burst.
  a_cpu_gap: assert property ($fell(dma_grant_o) |-> !dma_grant_o [*2])
    else $error("next burst without a gap");
  // Strobes stay high outside transfers and in the two-cycle method.
  a_strobe_idle: assert property (!dma_grant_o && !$past(dma_grant_o) |-> low_byte_strobe_n_o && high_byte_strobe_n_o)
    else $error("strobe low with no transfer");
  a_method_two: assert property (!one_cycle_o && !$past(one_cycle_o) |-> low_byte_strobe_n_o && high_byte_strobe_n_o)
    else $error("strobe low in two-cycle method");
  // An 8-bit bus only ever uses the low lane.
  a_width8_low: assert property (bus_width8_i && $past(bus_width8_i) |-> high_byte_strobe_n_o)
    else $error("high strobe on 8-bit bus");
  c_burst: cover property ($rose(dma_grant_o));
  c_pause: cover property (refresh_grant_o && $past(dma_grant_o));
  c_strobe: cover property (!low_byte_strobe_n_o);
endmodule // drbc_asserts
bind drbc_top drbc_asserts u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .refresh_req_i(refresh_req_i), .hold_req_i(hold_req_i), .bus_width8_i(bus_width8_i),
  .refresh_grant_o(refresh_grant_o), .hold_grant_o(hold_grant_o), .dma_grant_o(dma_grant_o),
  .cpu_grant_o(cpu_grant_o), .active_ch_o(active_ch_o), .one_cycle_o(one_cycle_o),
  .low_byte_strobe_n_o(low_byte_strobe_n_o), .high_byte_strobe_n_o(high_byte_strobe_n_o));
`default_nettype wire

// >>> verif/drbc_bus_model.sv
/*
  Far side of the bus: ends transfer cycles at an uneven pace and asks for
  refresh and hold now and then. Assumes the bench clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module drbc_bus_model (
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic dma_grant_i,
  output var logic  cycle_end_o,
  output var logic  addr_odd_o,
  output var logic  refresh_req_o,
  output var logic  hold_req_o
);
  logic [5:0] t_q;  // Free-running phase; uneven cycle lengths come from it.
  // Refresh and hold arrive mid-burst, so pauses and resumes get exercised.
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      t_q <= 6'h00;
      cycle_end_o <= 1'b0;
      addr_odd_o <= 1'b0;
      refresh_req_o <= 1'b0;
      hold_req_o <= 1'b0;
    end else begin
      t_q <= t_q + 6'h01;
      cycle_end_o <= dma_grant_i && !cycle_end_o && (t_q[0] | t_q[2]);
      if (cycle_end_o) addr_odd_o <= !addr_odd_o;
      refresh_req_o <= (t_q[5:2] == 4'hF);
      hold_req_o <= (t_q[5:3] == 3'h3);
    end
  end
endmodule // drbc_bus_model
`default_nettype wire

// >>> verif/testbench.sv
/*
  Self-checking bench for drbc_top: register reads queue their expected
  answers, a monitor compares them. Assumes the bus model as far side.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_i = 0, reset_n_i = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, bw8 = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [3:0] pin_n = 4'hF;
  logic [12:0] per = 0;
  wire awr, wr_rdy, bv, arr, rv, ce, odd, rfq, hdq, rg, hg, dg, cg, oc, ls, hs;
  wire [1:0] br, rr, act;
  wire [31:0] rdat;
  int bad_count = 0, n_compared = 0, c, i, cnt;
  logic [33:0] expq[$];  // Expected {rresp, rdata}, oldest first.
  always #5 mclk_i = ~mclk_i;
  drbc_top DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .channel_request_pin_n_i(pin_n),
    .terminate_transfer_pin_n_i(1'b1), .periph_req_i(per), .refresh_req_i(rfq),
    .hold_req_i(hdq), .bus_width8_i(bw8), .addr_odd_i(odd), .cycle_end_i(ce),
    .refresh_grant_o(rg), .hold_grant_o(hg), .dma_grant_o(dg), .cpu_grant_o(cg),
    .active_ch_o(act), .one_cycle_o(oc), .low_byte_strobe_n_o(ls), .high_byte_strobe_n_o(hs));
  drbc_bus_model u_bus (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .dma_grant_i(dg),
    .cycle_end_o(ce), .addr_odd_o(odd), .refresh_req_o(rfq), .hold_req_o(hdq));
  task end_sim;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_compared++;
    if (!ok) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task tmo;
    chk(1'b0, "wait timed out");
    end_sim();
  endtask
  // One write; address and data are released as each is taken.
  task wr(input [7:0] a, input [31:0] d);
    int n;
    @(posedge mclk_i);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_i);
      if (awr) awv <= 0;
      if (wr_rdy) wv <= 0;
      if (bv === 1'b1) break;
    end
    bry <= 0;
    if (n == 50) tmo();
  endtask
  // One read; the answer is judged by the monitor against the queue.
  task rd(input [7:0] a, input [33:0] e);
    int n;
    @(posedge mclk_i);
    ara <= a; arv <= 1; rry <= 1;
    expq.push_back(e);
    for (n = 0; n < 50; n++) begin
      @(posedge mclk_i);
      if (arr) arv <= 0;
      if (rv === 1'b1) break;
    end
    rry <= 0;
    if (n == 50) tmo();
  endtask
  // Waits for a burst grant and checks which channel owns it.
  task wait_g(input [1:0] ch);
    int n;
    for (n = 0; n < 300 && dg !== 1'b1; n++) @(posedge mclk_i);
    if (n == 300) tmo();
    chk(act === ch, "wrong owner channel");
  endtask
  // Idle means six CPU cycles in a row, so refresh pauses are not mistaken.
  task wait_idle;
    int n, k;
    k = 0;
    for (n = 0; n < 500 && k < 6; n++) begin
      @(posedge mclk_i);
      k = (cg === 1'b1) ? k + 1 : 0;
    end
    if (k < 6) tmo();
  endtask
  always @(posedge mclk_i)
    if (rv === 1'b1 && rry) begin
      if (expq.size() == 0) chk(1'b0, "unexpected read answer");
      else chk({rr, rdat} === expq.pop_front(), "read answer");
    end
  initial begin
    void'($urandom(83425));
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1;
    for (i = 0; i < 4; i++) begin
      rd(8'h10 + 8'(4 * i), 34'h0);
      rd(8'h20 + 8'(4 * i), 34'h0);
    end
    rd(8'h80, {2'b10, 32'h0});
    // Peripheral codes on a disabled edge-sensed channel: flag set except for code 0, no grant.
    for (c = 0; c < 16; c++) begin
      if (c == 1 || c == 2) continue;
      wr(8'h28, 32'(c));
      @(posedge mclk_i) per <= (c == 0) ? 13'h1FFF : 13'h0001 << (c - 3);
      @(posedge mclk_i) per <= 13'h0000;
      rd(8'h28, (c == 0) ? 34'h0 : 34'(c | 32'h20));
      chk(dg === 1'b0, "disabled channel got the bus");
    end
    wr(8'h28, 32'h0);
    // Software burst on channel 1; channel 0 edge arrives mid-burst.
    cnt = $urandom_range(4, 1);
    bw8 <= 1'($urandom());
    wr(8'h10, 32'h3); wr(8'h30, 32'(cnt)); wr(8'h20, 32'h41);
    wr(8'h14, 32'h2); wr(8'h34, 32'h2); wr(8'h24, 32'h42);
    wr(8'h00, 32'h200);
    wait_g(2'd1);
    pin_n[0] <= 1'b0;
    @(posedge mclk_i) pin_n[0] <= 1'b1;
    // Channel 1 must finish before channel 0 may be granted.
    for (i = 0; i < 300 && cg !== 1'b1; i++) @(posedge mclk_i);
    if (i == 300) tmo();
    wait_g(2'd0);
    wait_idle();
    rd(8'h00, 34'h0);
    rd(8'h24, 34'h2);
    rd(8'h20, 34'h1);
    rd(8'h30, 34'h0);
    // Level-sensed channel 3: pin release pauses, pin low resumes.
    wr(8'h1C, 32'h2); wr(8'h3C, 32'h6); wr(8'h2C, 32'h51);
    pin_n[3] <= 1'b0;
    wait_g(2'd3);
    pin_n[3] <= 1'b1;
    wait_idle();
    rd(8'h2C, 34'h51);
    pin_n[3] <= 1'b0;
    wait_g(2'd3);
    wait_idle();
    rd(8'h2C, 34'h31);
    pin_n[3] <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk(expq.size() === 0, "reads left unanswered");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
